// *** hw/rx_alarm_regs.svh ***
// Register map, field positions, reset values and alarm thresholds
`ifndef RX_ALARM_REGS_SVH
`define RX_ALARM_REGS_SVH

// =====================================================================
// Register indexes and byte addresses
`define IDX_ALARM_STATUS   8'h06
`define IDX_SYNC_STATE     8'h1e
`define IDX_RX_CONTROL     8'h20
`define ADDR_ALARM_STATUS  8'h18
`define ADDR_SYNC_STATE    8'h78
`define ADDR_RX_CONTROL    8'h80

// =====================================================================
// Field positions
`define BIT_SIG_ALL_ONES   3'h7
`define BIT_DISTANT_MF     3'h6
`define BIT_SIG_ALL_ZEROS  3'h5
`define BIT_STORE_SLIP     3'h4
`define BIT_UNFRAMED_ONES  3'h3
`define BIT_FAR_END        3'h2
`define BIT_CARRIER_LOST   3'h1
`define BIT_SYNC_LOST      3'h0
`define CTL_CRC_MODE       3'h0
`define CTL_EXT_CARRIER    3'h1

// =====================================================================
// Reset values
`define RST_CONTROL        2'h0
`define RST_FLAGS          8'h00

// =====================================================================
// Alarm thresholds and windows
`define CL_ZEROS_SHORT     12'h0ff
`define CL_ZEROS_LONG      12'h800
`define CL_WINDOW_LAST     8'hfe
`define CL_ONES_CLEAR      6'h20
`define UA_WINDOW_LAST     9'h1ff
`define FEW_ZEROS          3'h3
`define TS_SIGNALING       5'h10
`define MF_LAST_FRAME      4'hf
`define TS_LAST_BIT        3'h7
`define DMA_BIT            3'h5
`define FAR_END_BIT        3'h2

`endif

// *** hw/rx_alarm_pkg.sv ***
// Types shared by the receive alarm and synchronizer status block
package rx_alarm_pkg;

  // Position of the current received bit within the E1 structure
  typedef struct packed {
    logic [4:0] ts_index;     // Timeslot 0..31
    logic [2:0] bit_index;    // Bit 1..8 as 0..7
    logic [3:0] frame_index;  // Frame 0..15 of the multiframe
    logic       align_frame;  // Frame carries the alignment word
  } rx_timing_t;

  // Live synchronizer state from the framer
  typedef struct packed {
    logic fas_search;
    logic cas_search;
    logic crc_search;
    logic in_sync;
  } sync_status_t;

  // Whole state of the main module
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [7:0]  live;
    logic [7:0]  flags;
    logic [7:0]  snap;
    logic        armed;
    logic [3:0]  pend;
    logic        int_b;
    logic [5:0]  resync_cnt;
    logic [7:0]  sync_state;
    logic        crc_en;
    logic        ext_cl;
    logic [7:0]  cl_win;
    logic [8:0]  ua_win;
    logic        dma_prev;
    logic [1:0]  ra_hist;
    logic        ts16_one;
  } state_t;

endpackage

// *** hw/sat_count.sv ***
// Saturating up counter with synchronous clear and clock enable
`timescale 1ns/10ps
module sat_count #(
  parameter int W   = 4,
  parameter int MAX = 15
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic         ce,
  input  wire logic         clr,
  input  wire logic         inc,
  output logic [W-1:0]      count
);

  typedef struct packed {
    logic [W-1:0] count;
  } cnt_state_t;

  cnt_state_t s_r;
  cnt_state_t s_nxt;

  // Clear wins over increment; stop at the top value
  always_comb begin
    s_nxt = s_r;
    if (clr) begin
      s_nxt.count = '0;
    end else if (inc && (s_r.count != W'(MAX))) begin
      s_nxt.count = s_r.count + W'(1);
    end
  end

  // State register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign count = s_r.count;

endmodule // sat_count

// *** hw/rx_alarm_status.sv ***
// Receive alarm detection and synchronizer status with AXI4-Lite registers
//
// Operation
// - Six-bit resync count shown as bits 5..2 and 0 in status bits 7..3.
// - Synchronizer status is read-only, live, and needs no mask write.
// - Each expired 8 ms CRC multiframe search adds one to the count.
// - Reaching CRC multiframe sync clears the count.
// - CRC mode disabled holds the count at zero.
// - Count wraps from 63 to zero.
// - Fewer than three zeros in timeslot 16 per multiframe sets all-ones.
// - Timeslot 16 all zeros over a multiframe sets all-zeros.
// - Distant multiframe bit high twice sets alarm, low twice clears it.
// - Fewer than three zeros in 512 bits sets unframed all-ones.
// - Far-end bit high three times sets alarm, low three times clears.
// - 255 zeros, or 2048 in extended mode, set carrier loss.
// - At least 32 ones in a 255-bit window clear carrier loss.
// - Flags latch, clear on write-back, stay while condition persists.
// - Mask write refreshes chosen read bits; write-back clears them.
// - Changes of alarm bits 3..0 pull interrupt low until bit is read.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
`include "rx_alarm_regs.svh"
module rx_alarm_status (
  input  wire logic                        clock,
  input  wire logic                        rst_b,
  input  wire logic                        ce,
  input  wire logic                        rx_data,
  input  wire logic                        bit_en,
  input  wire rx_alarm_pkg::rx_timing_t    timing,
  input  wire rx_alarm_pkg::sync_status_t  sync,
  input  wire logic                        crc_timeout,
  input  wire logic                        crc_found,
  input  wire logic                        slip,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [7:0]                  awaddr,
  input  wire logic                        wvalid,
  output logic                             wready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  output logic                             bvalid,
  input  wire logic                        bready,
  output logic [1:0]                       bresp,
  input  wire logic                        arvalid,
  output logic                             arready,
  input  wire logic [7:0]                  araddr,
  output logic                             rvalid,
  input  wire logic                        rready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             int_b
);

  // ===================================================================
  // Declarations
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  rx_alarm_pkg::state_t s_r;
  rx_alarm_pkg::state_t s_nxt;

  logic [11:0] zero_run;
  logic [5:0]  cl_ones;
  logic [1:0]  ua_zeros;
  logic [1:0]  ts16_zeros;
  logic        ts16_bit;
  logic        ts16_last;
  logic        cl_last;
  logic        ua_last;
  logic        wr_fire;
  logic        rd_take;
  logic [11:0] cl_thresh;

  // ===================================================================
  // Bit-stream qualifiers
  assign ts16_bit  = bit_en && (timing.ts_index == `TS_SIGNALING);
  assign ts16_last = ts16_bit && (timing.bit_index == `TS_LAST_BIT)
                     && (timing.frame_index == `MF_LAST_FRAME);
  assign cl_last   = bit_en && (s_r.cl_win == `CL_WINDOW_LAST);
  assign ua_last   = bit_en && (s_r.ua_win == `UA_WINDOW_LAST);
  assign cl_thresh = s_r.ext_cl ? `CL_ZEROS_LONG : `CL_ZEROS_SHORT;
  assign wr_fire   = s_r.aw_held && s_r.w_held && !s_r.bvalid;
  assign rd_take   = arvalid && s_r.arready;

  // Run of consecutive zeros on the line
  sat_count #(.W(12), .MAX(2048)) u_zero_run (
    .clock (clock),
    .rst_b (rst_b),
    .ce    (ce),
    .clr   (bit_en && rx_data),
    .inc   (bit_en && !rx_data),
    .count (zero_run)
  );

  // Ones inside the current 255-bit window
  sat_count #(.W(6), .MAX(32)) u_cl_ones (
    .clock (clock),
    .rst_b (rst_b),
    .ce    (ce),
    .clr   (cl_last),
    .inc   (bit_en && rx_data),
    .count (cl_ones)
  );

  // Zeros inside the current 512-bit window
  sat_count #(.W(2), .MAX(3)) u_ua_zeros (
    .clock (clock),
    .rst_b (rst_b),
    .ce    (ce),
    .clr   (ua_last),
    .inc   (bit_en && !rx_data),
    .count (ua_zeros)
  );

  // Zeros in timeslot 16 over the current multiframe
  sat_count #(.W(2), .MAX(3)) u_ts16_zeros (
    .clock (clock),
    .rst_b (rst_b),
    .ce    (ce),
    .clr   (ts16_last),
    .inc   (ts16_bit && !rx_data),
    .count (ts16_zeros)
  );

  // ===================================================================
  // Next-state logic
  always_comb begin
    logic [7:0] clr_mask;
    logic [7:0] events;
    clr_mask = 8'h00;
    events   = 8'h00;
    s_nxt    = s_r;

    // Signaling alarms evaluated at the end of each multiframe
    if (ts16_last) begin
      s_nxt.live[`BIT_SIG_ALL_ONES] =
        ({1'b0, ts16_zeros} + {2'b00, !rx_data}) < `FEW_ZEROS;
      s_nxt.live[`BIT_SIG_ALL_ZEROS] = !(s_r.ts16_one || rx_data);
      s_nxt.ts16_one = 1'b0;
    end else if (ts16_bit && rx_data) begin
      s_nxt.ts16_one = 1'b1;
    end

    // Distant multiframe bit in frame 0 of timeslot 16
    if (ts16_bit && (timing.frame_index == 4'h0)
        && (timing.bit_index == `DMA_BIT)) begin
      s_nxt.dma_prev = rx_data;
      if (rx_data && s_r.dma_prev) begin
        s_nxt.live[`BIT_DISTANT_MF] = 1'b1;
      end else if (!rx_data && !s_r.dma_prev) begin
        s_nxt.live[`BIT_DISTANT_MF] = 1'b0;
      end
    end

    // Far-end alarm bit of the non-align frame
    if (bit_en && (timing.ts_index == 5'h00) && !timing.align_frame
        && (timing.bit_index == `FAR_END_BIT)) begin
      s_nxt.ra_hist = {s_r.ra_hist[0], rx_data};
      if (rx_data && (s_r.ra_hist == 2'h3)) begin
        s_nxt.live[`BIT_FAR_END] = 1'b1;
      end else if (!rx_data && (s_r.ra_hist == 2'h0)) begin
        s_nxt.live[`BIT_FAR_END] = 1'b0;
      end
    end

    // Unframed all-ones over 512-bit windows
    if (bit_en) begin
      s_nxt.ua_win = s_r.ua_win + 9'h001;
    end
    if (ua_last) begin
      s_nxt.live[`BIT_UNFRAMED_ONES] =
        ({1'b0, ua_zeros} + {2'b00, !rx_data}) < `FEW_ZEROS;
    end

    // Carrier loss: zero run sets, ones in a 255-bit window clear
    if (bit_en) begin
      s_nxt.cl_win = cl_last ? 8'h00 : s_r.cl_win + 8'h01;
    end
    if (bit_en && !rx_data && ((zero_run + 12'h001) >= cl_thresh)) begin
      s_nxt.live[`BIT_CARRIER_LOST] = 1'b1;
    end else if (cl_last && rx_data
                 && ((cl_ones + 6'h01) >= `CL_ONES_CLEAR)) begin
      s_nxt.live[`BIT_CARRIER_LOST] = 1'b0;
    end else if (cl_last && !rx_data && (cl_ones >= `CL_ONES_CLEAR)) begin
      s_nxt.live[`BIT_CARRIER_LOST] = 1'b0;
    end

    // Sync lost follows the framer directly
    s_nxt.live[`BIT_SYNC_LOST] = !sync.in_sync;
    s_nxt.live[`BIT_STORE_SLIP] = 1'b0;
    events[`BIT_STORE_SLIP] = slip;

    // CRC resync attempt counter
    if (!s_r.crc_en) begin
      s_nxt.resync_cnt = 6'h00;
    end else if (crc_found) begin
      s_nxt.resync_cnt = 6'h00;
    end else if (crc_timeout) begin
      s_nxt.resync_cnt = s_r.resync_cnt + 6'h01;
    end

    // Live synchronizer state, never latched
    s_nxt.sync_state = {s_nxt.resync_cnt[5:2], s_nxt.resync_cnt[0],
                        sync.fas_search, sync.cas_search,
                        sync.crc_search};

    // Interrupt pending on every change of condition alarm bits 3..0
    s_nxt.pend = s_r.pend;
    if (rd_take && (araddr == `ADDR_ALARM_STATUS)) begin
      s_nxt.pend = s_r.pend & ~s_r.snap[3:0];
    end
    s_nxt.pend = s_nxt.pend | (s_nxt.live[3:0] ^ s_r.live[3:0]);

    // Write address and data channels, taken in either order
    if (awvalid && s_r.awready) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = awaddr;
    end
    if (wvalid && s_r.wready) begin
      s_nxt.w_held  = 1'b1;
      s_nxt.w_data  = wdata[7:0];
      s_nxt.w_lane0 = wstrb[0];
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_fire) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = RESP_OKAY;
      case (s_r.aw_addr)
        `ADDR_ALARM_STATUS: begin
          if (s_r.w_lane0 && s_r.armed) begin
            clr_mask    = s_r.w_data;
            s_nxt.armed = 1'b0;
          end else if (s_r.w_lane0) begin
            s_nxt.snap = (s_r.snap & ~s_r.w_data)
                         | (s_r.flags & s_r.w_data);
          end
        end
        `ADDR_SYNC_STATE: begin
          s_nxt.bresp = RESP_OKAY;
        end
        `ADDR_RX_CONTROL: begin
          if (s_r.w_lane0) begin
            s_nxt.crc_en = s_r.w_data[`CTL_CRC_MODE];
            s_nxt.ext_cl = s_r.w_data[`CTL_EXT_CARRIER];
          end
        end
        default: begin
          s_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end
    s_nxt.awready = !s_nxt.aw_held;
    s_nxt.wready  = !s_nxt.w_held;

    // Latched flags: set wins over the write-back clear
    s_nxt.flags = (s_r.flags & ~clr_mask) | s_r.live | events;

    // Read channel, one read under way at a time
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid  = 1'b0;
      s_nxt.arready = 1'b1;
    end
    if (rd_take) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid  = 1'b1;
      s_nxt.rresp   = RESP_OKAY;
      s_nxt.rdata   = 32'h0000_0000;
      case (araddr)
        `ADDR_ALARM_STATUS: begin
          s_nxt.rdata[7:0] = s_r.snap;
          s_nxt.armed      = 1'b1;
        end
        `ADDR_SYNC_STATE: begin
          s_nxt.rdata[7:0] = s_r.sync_state;
        end
        `ADDR_RX_CONTROL: begin
          s_nxt.rdata[1:0] = {s_r.ext_cl, s_r.crc_en};
        end
        default: begin
          s_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end

    s_nxt.int_b = ~|s_nxt.pend;
  end

  // State register, frozen while ce is low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_r         <= '0;
      s_r.awready <= 1'b1;
      s_r.wready  <= 1'b1;
      s_r.arready <= 1'b1;
      s_r.int_b   <= 1'b1;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign awready = s_r.awready;
  assign wready  = s_r.wready;
  assign bvalid  = s_r.bvalid;
  assign bresp   = s_r.bresp;
  assign arready = s_r.arready;
  assign rvalid  = s_r.rvalid;
  assign rdata   = s_r.rdata;
  assign rresp   = s_r.rresp;
  assign int_b   = s_r.int_b;

  // ===================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_count_increment: assert property (
    ce && s_r.crc_en && !crc_found && crc_timeout
    |=> s_r.resync_cnt == 6'($past(s_r.resync_cnt) + 6'h01))
    else $error("resync count did not increment");
  a_count_wraps: assert property (
    ce && s_r.crc_en && !crc_found && crc_timeout && s_r.resync_cnt == 6'h3f
    |=> s_r.resync_cnt == 6'h00)
    else $error("resync count did not wrap");
  a_count_sync_clear: assert property (
    ce && crc_found |=> s_r.resync_cnt == 6'h00)
    else $error("resync count not cleared on sync");
  a_count_mode_clear: assert property (
    ce && !s_r.crc_en |=> s_r.resync_cnt == 6'h00)
    else $error("resync count not held at zero");
  a_sync_state_map: assert property (
    s_r.sync_state[7:3] == {s_r.resync_cnt[5:2], s_r.resync_cnt[0]})
    else $error("sync state count bits misplaced");
  a_search_live: assert property (
    ce |=> s_r.sync_state[2:0] ==
    {$past(sync.fas_search), $past(sync.cas_search), $past(sync.crc_search)})
    else $error("search bits not live");
  a_sync_lost_flag: assert property (
    ce && !sync.in_sync |=> s_r.live[0] ##1 (!ce || s_r.flags[0]))
    else $error("sync lost not flagged");
  a_slip_flag: assert property (
    ce && slip |=> s_r.flags[4])
    else $error("slip not flagged");
  a_flag_persists: assert property (
    ce && s_r.live[1] |=> s_r.flags[1])
    else $error("carrier flag cleared while alarm present");
  a_carrier_short: assert property (
    ce && bit_en && !rx_data && !s_r.ext_cl && zero_run == 12'h0fe
    |=> s_r.live[1])
    else $error("carrier loss not set at 255 zeros");
  a_far_end_set: assert property (
    ce && bit_en && timing.ts_index == 5'h00 && !timing.align_frame
    && timing.bit_index == 3'h2 && rx_data && s_r.ra_hist == 2'h3
    |=> s_r.live[2])
    else $error("far end alarm not set");
  a_int_on_change: assert property (
    ce && (s_nxt.live[3:0] != s_r.live[3:0]) |=> !int_b)
    else $error("interrupt not raised on alarm change");
  a_mask_refresh: assert property (
    ce && wr_fire && !s_r.armed && s_r.w_lane0
    && s_r.aw_addr == `ADDR_ALARM_STATUS
    |=> (s_r.snap & $past(s_r.w_data)) == ($past(s_r.flags) & $past(s_r.w_data)))
    else $error("masked snapshot bits not refreshed");

  c_count_wrap: cover property (ce && crc_timeout && s_r.resync_cnt == 6'h3f);
  c_carrier_lost: cover property (s_r.live[1]);
  c_status_read: cover property (rd_take && araddr == `ADDR_ALARM_STATUS);
  c_interrupt: cover property (!int_b);

endmodule // rx_alarm_status

// *** testbench/e1_line_src.sv ***
// Incoming E1 line model: bit pacing, frame position and a fixed line level
`timescale 1ns/10ps
module e1_line_src (
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  input  wire logic                 run,
  input  wire logic                 level,
  output logic                      rx_data,
  output logic                      bit_en,
  output rx_alarm_pkg::rx_timing_t  timing
);
  logic [11:0] pos_r;  // Frame, timeslot and bit in the multiframe

  // =====================================================================
  // Bit pacing
  // One bit every second clock; between bits the line shows the inverse
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pos_r   <= 12'h000;
      bit_en  <= 1'b0;
      rx_data <= 1'b0;
    end else if (run && !bit_en) begin
      bit_en  <= 1'b1;
      rx_data <= level;
    end else begin
      if (bit_en) begin
        pos_r <= pos_r + 12'h001;
      end
      bit_en  <= 1'b0;
      rx_data <= ~rx_data;
    end
  end

  // Position of the bit now offered, even frames carry alignment
  assign timing = {pos_r[7:3], pos_r[2:0], pos_r[11:8], ~pos_r[8]};
endmodule // e1_line_src

// *** testbench/tb_top.sv ***
// Self-checking bench for the receive alarm and synchronizer status block
`timescale 1ns/10ps
`include "rx_alarm_regs.svh"
module tb_top;
  logic                       clock, rst_b, ce, rx_data, bit_en, int_b;
  logic                       crc_timeout, crc_found, slip, run, level;
  logic                       awvalid, awready, wvalid, wready, bvalid, bready;
  logic                       arvalid, arready, rvalid, rready;
  logic [7:0]                 awaddr, araddr;
  logic [31:0]                wdata, rdata, rd;
  logic [3:0]                 wstrb;
  logic [1:0]                 bresp, rresp, rs;
  rx_alarm_pkg::rx_timing_t   timing;
  rx_alarm_pkg::sync_status_t sync;
  int                         err_total, checks;

  rx_alarm_status DUT (.clock, .rst_b, .ce, .rx_data, .bit_en, .timing, .sync,
    .crc_timeout, .crc_found, .slip, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .int_b);
  e1_line_src line (.clock, .rst_b, .run, .level, .rx_data, .bit_en, .timing);

  // =====================================================================
  // Clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // =====================================================================
  // Shared tasks
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // A bus wait that ran out ends the run
  task automatic hang(input int n);
    if (n >= 100) begin
      err_total++;
      $display("BAD at %0t: bus gave no answer", $time);
      end_sim();
    end
  endtask

  // Bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clock);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    rs = bresp;
    hang(n);
  endtask

  // Bus read: data and response taken at the edge that shows rvalid
  task automatic rd_reg(input logic [7:0] a);
    int n;
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
    hang(n);
  endtask

  // Host mask write, read, then write back the read value under the mask
  task automatic poll(input logic [7:0] m, input logic [7:0] e);
    wr(`ADDR_ALARM_STATUS, {24'h00_0000, m}, 4'hf);
    rd_reg(`ADDR_ALARM_STATUS);
    check(rd, {24'h00_0000, e});
    wr(`ADDR_ALARM_STATUS, rd & {24'h00_0000, m}, 4'hf);
  endtask

  // Synchronizer word: count bits 5..2 and 0, then three search flags
  task automatic sync_chk(input logic [5:0] c, input logic [2:0] s);
    rd_reg(`ADDR_SYNC_STATE);
    check(rd, {24'h00_0000, c[5:2], c[0], s});
  endtask

  // Expired CRC multiframe searches
  task automatic pulse_to(input int n);
    repeat (n) begin
      @(posedge clock);
      crc_timeout <= 1'b1;
      @(posedge clock);
      crc_timeout <= 1'b0;
    end
  endtask

  // =====================================================================
  // Scenarios
  // Reset values, unmapped address, ignored writes
  task automatic t_regs();
    rd_reg(`ADDR_RX_CONTROL);
    check(rd, 32'h0000_0000);
    rd_reg(8'h40);
    check(rd, 32'h0000_0000);
    check(rs, 2'h2);
    wr(`ADDR_SYNC_STATE, 32'h0000_00ff, 4'hf);
    check(rs, 2'h0);
    sync_chk(6'h00, 3'h0);
    wr(`ADDR_RX_CONTROL, 32'h0000_0001, 4'he);
    rd_reg(`ADDR_RX_CONTROL);
    check(rd, 32'h0000_0000);
  endtask

  // Slip event and loss of sync, latched and released
  task automatic t_events();
    @(posedge clock);
    slip         <= 1'b1;
    sync.in_sync <= 1'b0;
    @(posedge clock);
    slip <= 1'b0;
    repeat (4) @(posedge clock);
    check(int_b, 1'b0);
    poll(8'h11, 8'h11);
    @(posedge clock);
    sync.in_sync <= 1'b1;
    repeat (4) @(posedge clock);
    poll(8'h11, 8'h01);
    poll(8'h11, 8'h00);
    check(int_b, 1'b1);
  endtask

  // Search flags and the resync attempt count
  task automatic t_resync();
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      sync <= {3'b001 << i, 1'b1};
      repeat (2) @(posedge clock);
      sync_chk(6'h00, 3'b001 << i);
    end
    wr(`ADDR_RX_CONTROL, 32'h0000_0001, 4'hf);
    pulse_to(5);
    sync_chk(6'h05, 3'b100);
    // Fifty expired 8 ms searches mark the host's 400 ms give-up point
    pulse_to(45);
    sync_chk(6'h32, 3'b100);
    pulse_to(13);
    sync_chk(6'h3f, 3'b100);
    pulse_to(1);
    sync_chk(6'h00, 3'b100);
    pulse_to(3);
    sync_chk(6'h03, 3'b100);
    @(posedge clock);
    crc_found <= 1'b1;
    @(posedge clock);
    crc_found <= 1'b0;
    sync_chk(6'h00, 3'b100);
    pulse_to(3);
    wr(`ADDR_RX_CONTROL, 32'h0000_0000, 4'hf);
    sync_chk(6'h00, 3'b100);
    pulse_to(1);
    sync_chk(6'h00, 3'b100);
  endtask

  // Three multiframes of all ones
  task automatic t_ones();
    @(posedge clock);
    level <= 1'b1;
    run   <= 1'b1;
    repeat (24576) @(posedge clock);
    check(int_b, 1'b0);
    poll(8'hff, 8'hcc);
    repeat (2) @(posedge clock);
    check(int_b, 1'b1);
  endtask

  // Three multiframes of all zeros, long carrier threshold selected
  task automatic t_zeros();
    wr(`ADDR_RX_CONTROL, 32'h0000_0002, 4'hf);
    @(posedge clock);
    level <= 1'b0;
    // About 600 zeros: past 255 but short of 2048, so no carrier loss yet
    repeat (1200) @(posedge clock);
    poll(8'h02, 8'hcc);
    repeat (23361) @(posedge clock);
    poll(8'hff, 8'hee);
    poll(8'hff, 8'h22);
    check(int_b, 1'b1);
  endtask

  // Ones return for 1600 bits: carrier back, unframed and far-end alarms set
  task automatic t_back();
    @(posedge clock);
    level <= 1'b1;
    repeat (3200) @(posedge clock);
    check(int_b, 1'b0);
    poll(8'hff, 8'h2e);
    poll(8'hff, 8'h2c);
  endtask

  // =====================================================================
  // Main sequence
  initial begin
    rst_b       = 1'b0;
    ce          = 1'b1;
    run         = 1'b0;
    level       = 1'b1;
    sync        = {3'b000, 1'b1};
    crc_timeout = 1'b0;
    crc_found   = 1'b0;
    slip        = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr      = 8'h00;
    araddr      = 8'h00;
    wdata       = 32'h0000_0000;
    wstrb       = 4'h0;
    err_total   = 0;
    checks      = 0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    t_regs();
    t_events();
    t_resync();
    t_ones();
    t_zeros();
    t_back();
    end_sim();
  end
endmodule // tb_top
